// >>> src/adc_conversion_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctl_defines.svh"
// How it works
// - Disabled in reset or channel all ones
// - Idle after completion until next start
// - Converts the software selected channel
// - Twelve and ten bit modes yield 12 bits
// - Eight bit mode yields nine raw bits
// - Completion writes the low result, and the high one outside eight bit mode
// - Ten bit mode rounds to ten bits
// - Eight bit mode rounds, low register only
// - Complete flag set after result stored
// - Flag with enable raises interrupt
// - Compare enable checks each result
// - Compare works with every mode
// - Upper pin bits release pins 23..16
module adc_conversion_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_high,
  output logic [11:0] dac_trial,
  output logic [4:0] channel_sel,
  output logic analog_enable,
  output logic sampling,
  output logic [7:0] pin_io_disable,
  output logic irq
);
  adc_ctl_pkg::conv_state_t state_reg;
  adc_ctl_pkg::conv_cfg_t cfg_reg;
  logic [4:0] channel_select_field;
  logic complete_irq_enable;
  logic conversion_complete_flag;
  logic [11:0] result_high_reg;
  logic [11:0] result_low_reg;
  logic [11:0] compare_reg;
  logic [7:0] adc_pin_control_upper;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_enable_reg;
  logic [7:0] div_reg;
  logic step;
  logic wr_en;
  logic rd_en;
  logic start;
  logic sar_start;
  logic sar_done;
  logic [11:0] sar_result;
  logic [11:0] sar_trial;
  logic [11:0] stored;
  logic [11:0] cmp_value;
  logic cmp_hit;
  logic disabled;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign start = wr_en && paddr == `OFF_STATUS_CTRL;
  assign disabled = channel_select_field == `CH_ALL_ONES;
  assign channel_sel = channel_select_field;
  assign analog_enable = !disabled && state_reg != adc_ctl_pkg::ST_IDLE;
  assign sampling = state_reg == adc_ctl_pkg::ST_SAMPLE;
  assign pin_io_disable = adc_pin_control_upper;
  assign irq = |(irq_status_reg & irq_enable_reg);

  function automatic logic [3:0] mode_bits(input logic [1:0] mode);
    if (mode == `MODE_8) begin
      mode_bits = 4'h9;
    end else begin
      mode_bits = 4'hc;
    end
  endfunction

  function automatic logic [11:0] round_result(input logic [1:0] mode, input logic [11:0] raw);
    logic [12:0] sum;
    sum = 13'h0;
    case (mode)
      `MODE_8: begin
        sum = {4'h0, raw[8:0]} + 13'h1;
        round_result = (sum[9]) ? 12'h0ff : {4'h0, sum[8:1]};
      end
      `MODE_10: begin
        sum = {1'b0, raw} + 13'h2;
        round_result = (sum[12]) ? 12'h3ff : {2'h0, sum[11:2]};
      end
      default: begin
        round_result = raw;
      end
    endcase
  endfunction

  assign stored = round_result(cfg_reg.mode, sar_result);
  // compare value built per mode
  // Eight bit mode leaves the high register stale, so mask it out
  assign cmp_value = (cfg_reg.mode == `MODE_8) ? {4'h0, result_low_reg[7:0]}
    : {result_high_reg[3:0], result_low_reg[7:0]};
  assign cmp_hit = cfg_reg.cmp_gt ? (cmp_value >= compare_reg) : (cmp_value < compare_reg);
  // nine bit trial left aligned
  // Keeps the comparator at full scale in every mode
  assign dac_trial = (cfg_reg.mode == `MODE_8) ? (sar_trial << 3) : sar_trial;

  sar_stepper #(.WIDTH(12)) u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .start(sar_start),
    .step(step),
    .nbits(mode_bits(cfg_reg.mode)),
    .cmp_high(cmp_high),
    .trial(sar_trial),
    .result(sar_result),
    .done(sar_done)
  );

  assign sar_start = state_reg == adc_ctl_pkg::ST_SAMPLE && step;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 8'h00;
    end else if (state_reg == adc_ctl_pkg::ST_IDLE || div_reg == `STEP_DIV - 8'h01) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  assign step = div_reg == `STEP_DIV - 8'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= adc_ctl_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        adc_ctl_pkg::ST_IDLE: begin
          if (start && pwdata[`CH_FIELD_W-1:0] != `CH_ALL_ONES) begin
            state_reg <= adc_ctl_pkg::ST_SAMPLE;
          end
        end
        adc_ctl_pkg::ST_SAMPLE: begin
          if (step) begin
            state_reg <= adc_ctl_pkg::ST_APPROX;
          end
        end
        adc_ctl_pkg::ST_APPROX: begin
          if (sar_done) begin
            state_reg <= adc_ctl_pkg::ST_STORE;
          end
        end
        adc_ctl_pkg::ST_STORE: begin
          state_reg <= adc_ctl_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= adc_ctl_pkg::ST_IDLE;
        end
      endcase
      if (start && pwdata[`CH_FIELD_W-1:0] == `CH_ALL_ONES) begin
        state_reg <= adc_ctl_pkg::ST_IDLE;
      end else if (start && state_reg != adc_ctl_pkg::ST_IDLE) begin
        state_reg <= adc_ctl_pkg::ST_SAMPLE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_select_field <= `CH_ALL_ONES;
      complete_irq_enable <= 1'b0;
      cfg_reg <= '0;
      compare_reg <= 12'h000;
      adc_pin_control_upper <= 8'h00;
      irq_enable_reg <= 2'h0;
    end else if (wr_en) begin
      case (paddr)
        `OFF_STATUS_CTRL: begin
          channel_select_field <= pwdata[`CH_FIELD_W-1:0];
          complete_irq_enable <= pwdata[`BIT_IRQ_EN];
        end
        `OFF_CONFIG: begin
          cfg_reg.mode <= pwdata[`MODE_LSB+1:`MODE_LSB];
          cfg_reg.cmp_en <= pwdata[`BIT_CMP_EN];
          cfg_reg.cmp_gt <= pwdata[`BIT_CMP_GT];
        end
        `OFF_COMPARE: compare_reg <= pwdata[11:0];
        `OFF_PIN_CTL_UPPER: adc_pin_control_upper <= pwdata[7:0];
        `OFF_IRQ_ENABLE: irq_enable_reg <= pwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_high_reg <= 12'h000;
      result_low_reg <= 12'h000;
    end else if (state_reg == adc_ctl_pkg::ST_APPROX && sar_done) begin
      result_low_reg <= {4'h0, stored[7:0]};
      if (cfg_reg.mode != `MODE_8) begin
        result_high_reg <= {8'h00, stored[11:8]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_complete_flag <= 1'b0;
    end else if (state_reg == adc_ctl_pkg::ST_STORE) begin
      conversion_complete_flag <= 1'b1;
    end else if (start) begin
      conversion_complete_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= 2'h0;
    end else begin
      irq_status_reg[`IRQ_COMPLETE] <= (state_reg == adc_ctl_pkg::ST_STORE && complete_irq_enable)
        || (irq_status_reg[`IRQ_COMPLETE] && !(wr_en && paddr == `OFF_IRQ_CLEAR && pwdata[0]));
      irq_status_reg[`IRQ_COMPARE] <= (state_reg == adc_ctl_pkg::ST_STORE && cfg_reg.cmp_en
        && cmp_hit)
        || (irq_status_reg[`IRQ_COMPARE] && !(wr_en && paddr == `OFF_IRQ_CLEAR && pwdata[1]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFF_STATUS_CTRL: prdata <= {24'h0, conversion_complete_flag, complete_irq_enable, 1'b0,
          channel_select_field};
        `OFF_CONFIG: prdata <= {26'h0, cfg_reg.cmp_en, cfg_reg.cmp_gt, cfg_reg.mode, 2'h0};
        `OFF_RESULT_HIGH: prdata <= {20'h0, result_high_reg};
        `OFF_RESULT_LOW: prdata <= {20'h0, result_low_reg};
        `OFF_COMPARE: prdata <= {20'h0, compare_reg};
        `OFF_PIN_CTL_UPPER: prdata <= {24'h0, adc_pin_control_upper};
        `OFF_IRQ_STATUS: prdata <= {30'h0, irq_status_reg};
        `OFF_IRQ_ENABLE: prdata <= {30'h0, irq_enable_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  flag_after_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(conversion_complete_flag) |-> $past(state_reg) == adc_ctl_pkg::ST_STORE)
    else $error("Complete flag rose without store");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(conversion_complete_flag) && $past(complete_irq_enable)
      && irq_enable_reg[`IRQ_COMPLETE] |-> irq)
    else $error("Interrupt missing after completion");
  disabled_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    disabled |-> state_reg == adc_ctl_pkg::ST_IDLE && !analog_enable)
    else $error("Converter active while disabled");
  idle_after_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == adc_ctl_pkg::ST_STORE && !start |=> state_reg == adc_ctl_pkg::ST_IDLE)
    else $error("Not idle after store");
  start_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    start && state_reg != adc_ctl_pkg::ST_STORE |=> !conversion_complete_flag)
    else $error("Start did not clear flag");
  pin_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `OFF_PIN_CTL_UPPER |=> pin_io_disable == $past(pwdata[7:0]))
    else $error("Pin control mismatch");
  low_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(conversion_complete_flag) && cfg_reg.mode == `MODE_8
      |-> result_low_reg <= 12'h0ff && result_high_reg == $past(result_high_reg, 2))
    else $error("Eight bit result too wide or high register touched");
  high_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(conversion_complete_flag) && cfg_reg.mode == `MODE_10 |-> result_high_reg <= 12'h003)
    else $error("Ten bit result too wide");
  cmp_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == adc_ctl_pkg::ST_STORE && cfg_reg.cmp_en && cmp_hit |=> irq_status_reg[`IRQ_COMPARE])
    else $error("Compare hit not recorded");
endmodule
`default_nettype wire

// >>> src/adc_ctl_defines.svh
`ifndef ADC_CTL_DEFINES_SVH
`define ADC_CTL_DEFINES_SVH
`define OFF_STATUS_CTRL 12'h000
`define OFF_CONFIG 12'h004
`define OFF_RESULT_HIGH 12'h008
`define OFF_RESULT_LOW 12'h00c
`define OFF_COMPARE 12'h010
`define OFF_PIN_CTL_UPPER 12'h014
`define OFF_IRQ_STATUS 12'h018
`define OFF_IRQ_ENABLE 12'h01c
`define OFF_IRQ_CLEAR 12'h020
`define CH_FIELD_LSB 0
`define CH_FIELD_W 5
`define CH_ALL_ONES 5'h1f
`define BIT_IRQ_EN 6
`define BIT_COMPLETE 7
`define BIT_CMP_EN 5
`define BIT_CMP_GT 4
`define MODE_LSB 2
`define MODE_8 2'h0
`define MODE_12 2'h1
`define MODE_10 2'h2
`define STEP_DIV 8'h04
`define IRQ_COMPLETE 0
`define IRQ_COMPARE 1
`endif

// >>> src/adc_ctl_pkg.sv
package adc_ctl_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_APPROX = 4'b0100,
    ST_STORE = 4'b1000
  } conv_state_t;
  typedef struct packed {
    logic [1:0] mode;
    logic cmp_en;
    logic cmp_gt;
    logic [4:0] channel;
  } conv_cfg_t;
endpackage

// >>> src/sar_stepper.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctl_defines.svh"
// Successive approximation walk, MSB first, one bit per step pulse
module sar_stepper #(
  parameter int WIDTH = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic step,
  input wire logic [3:0] nbits,
  input wire logic cmp_high,
  output logic [WIDTH-1:0] trial,
  output logic [WIDTH-1:0] result,
  output logic done
);
  logic [WIDTH-1:0] trial_reg;
  logic [WIDTH-1:0] acc_reg;
  logic [3:0] idx_reg;
  logic busy_reg;
  logic done_reg;
  assign trial = trial_reg;
  assign result = acc_reg;
  assign done = done_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trial_reg <= '0;
      acc_reg <= '0;
      idx_reg <= 4'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        idx_reg <= nbits - 4'h1;
        acc_reg <= '0;
        trial_reg <= WIDTH'(1) << (nbits - 4'h1);
        busy_reg <= 1'b1;
      end else if (busy_reg && step) begin
        if (cmp_high) begin
          acc_reg <= trial_reg;
        end
        if (idx_reg == 4'h0) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          idx_reg <= idx_reg - 4'h1;
          trial_reg <= (cmp_high ? trial_reg : acc_reg) | (WIDTH'(1) << (idx_reg - 4'h1));
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/analog_inputs.sv
`timescale 1ns/10ps
`default_nettype none
module analog_inputs (
  input wire logic pclk,
  input wire logic [11:0] level,
  input wire logic [4:0] channel_sel,
  input wire logic [11:0] dac_trial,
  input wire logic analog_enable,
  output logic cmp_high
);
  logic idle_toggle = 1'b0;
  // Undriven comparator wanders, never a stale value
  always @(posedge pclk) begin
    idle_toggle <= ~idle_toggle;
  end
  // each channel has its own voltage
  assign cmp_high = analog_enable ? ((level ^ {channel_sel, 7'h00}) >= dac_trial) : idle_toggle;
endmodule
`default_nettype wire

// >>> bench/adc_conversion_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctl_defines.svh"
module adc_conversion_control_tb;
  typedef struct packed {
    logic [4:0] ch;
    logic [1:0] mode;
    logic [11:0] v;
    logic [7:0] hi;
    logic [7:0] lo;
  } row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] level = 12'h000;
  logic [31:0] prdata;
  logic pready, pslverr, cmp_high, analog_enable, sampling, irq;
  logic [11:0] dac_trial;
  logic [4:0] channel_sel;
  logic [7:0] pin_io_disable;
  logic [31:0] rd;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  // 8-bit rows keep the high byte of the row before
  row_t rows [6] = '{
    '{5'h00, `MODE_12, 12'ha5c, 8'h0a, 8'h5c},
    '{5'h03, `MODE_10, 12'h3ff, 8'h01, 8'h00},
    '{5'h11, `MODE_10, 12'hffe, 8'h03, 8'hff},
    '{5'h08, `MODE_8, 12'h7f8, 8'h03, 8'h80},
    '{5'h1e, `MODE_8, 12'hfff, 8'h03, 8'hff},
    '{5'h01, `MODE_12, 12'h000, 8'h00, 8'h00}};
  adc_conversion_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_high(cmp_high), .dac_trial(dac_trial),
    .channel_sel(channel_sel), .analog_enable(analog_enable), .sampling(sampling),
    .pin_io_disable(pin_io_disable), .irq(irq));
  analog_inputs pins (.pclk(pclk), .level(level), .channel_sel(channel_sel),
    .dac_trial(dac_trial), .analog_enable(analog_enable), .cmp_high(cmp_high));
  initial begin
    forever #2 pclk = ~pclk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Generous ceiling, full run needs about a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, `OFF_STATUS_CTRL, 32'h0);
      if (rd[`BIT_COMPLETE] === 1'b1) break;
    end
    chk("complete", rd[`BIT_COMPLETE], 32'h1);
    chk("idle enable", analog_enable, 32'h0);
    chk("idle sampling", sampling, 32'h0);
  endtask
  task automatic convert(input logic [4:0] ch, input logic [11:0] v, input logic ie);
    level <= v ^ {ch, 7'h00};
    apb(1'b1, `OFF_STATUS_CTRL, {25'h0, ie, 1'b0, ch});
    wait_done();
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("reset channel", channel_sel, 32'h1f);
    chk("reset enable", analog_enable, 32'h0);
    chk("reset pins", pin_io_disable, 32'h0);
    chk("reset irq", irq, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, `OFF_CONFIG, {28'h0, rows[i].mode, 2'h0});
      convert(rows[i].ch, rows[i].v, 1'b0);
      apb(1'b0, `OFF_RESULT_HIGH, 32'h0);
      chk("result high", rd[7:0], rows[i].hi);
      apb(1'b0, `OFF_RESULT_LOW, 32'h0);
      chk("result low", rd[7:0], rows[i].lo);
    end
    $display("test conversion rows done");
    apb(1'b1, `OFF_PIN_CTL_UPPER, 32'ha5);
    @(posedge pclk);
    chk("pin disable", pin_io_disable, 32'ha5);
    apb(1'b0, `OFF_PIN_CTL_UPPER, 32'h0);
    chk("pin readback", rd, 32'ha5);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("slverr", pslverr, 32'h0);
    $display("test registers done");
    apb(1'b1, `OFF_IRQ_ENABLE, 32'h1);
    convert(5'h02, 12'h123, 1'b1);
    chk("irq raised", irq, 32'h1);
    apb(1'b1, `OFF_IRQ_ENABLE, 32'h0);
    @(posedge pclk);
    chk("irq masked", irq, 32'h0);
    apb(1'b1, `OFF_IRQ_ENABLE, 32'h1);
    apb(1'b1, `OFF_IRQ_CLEAR, 32'h1);
    apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
    chk("irq cleared", rd[1:0], 32'h0);
    convert(5'h02, 12'h123, 1'b0);
    chk("irq disabled", irq, 32'h0);
    apb(1'b1, `OFF_STATUS_CTRL, 32'h2);
    apb(1'b0, `OFF_STATUS_CTRL, 32'h0);
    chk("flag cleared", rd[`BIT_COMPLETE], 32'h0);
    wait_done();
    $display("test interrupt done");
    apb(1'b1, `OFF_COMPARE, 32'h100);
    apb(1'b1, `OFF_IRQ_ENABLE, 32'h2);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `OFF_IRQ_CLEAR, 32'h3);
      apb(1'b1, `OFF_CONFIG, {26'h0, 1'b1, k != 1, (k == 2) ? `MODE_10 : `MODE_12, 2'h0});
      convert(5'h00, 12'ha5c, 1'b0);
      convert(5'h00, 12'ha5c, 1'b0);
      apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
      chk("compare hit", rd[1], k != 1);
      chk("compare irq", irq, k != 1);
    end
    $display("test compare done");
    level <= 12'h800;
    apb(1'b1, `OFF_STATUS_CTRL, 32'h2);
    apb(1'b1, `OFF_STATUS_CTRL, 32'h1f);
    repeat (2) @(posedge pclk);
    chk("abort enable", analog_enable, 32'h0);
    repeat (80) @(posedge pclk);
    apb(1'b0, `OFF_STATUS_CTRL, 32'h0);
    chk("abort flag", rd[`BIT_COMPLETE], 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("rereset channel", channel_sel, 32'h1f);
    chk("rereset pins", pin_io_disable, 32'h0);
    $display("test disable and reset done");
    final_report();
  end
endmodule
`default_nettype wire
